// *** core/pm_mux.sv ***
//------------------------------------------------------------
// Purpose: Port 1 and port 2 pin function multiplexer
// Assumes: APB master, pads and transceiver outside
// Notes: All outputs registered; pad inputs synchronised
//------------------------------------------------------------
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
module pm_mux (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   // Register bus
   input wire pm_pkg::apb_req_t APB_I,
   output pm_pkg::apb_rsp_t APB_O,
   // Port 1 pads
   input wire logic [1:0] P1_PAD_I,
   output logic [1:0] P1_PAD_O,
   output logic [1:0] P1_PAD_OE_O,
   // Port 2 pads
   input wire logic [1:0] P2_PAD_I,
   output logic [1:0] P2_PAD_O,
   output logic [1:0] P2_PAD_OE_O,
   // UART side
   input wire logic UART_TX_I,
   output logic UART_RX_O,
   // Transceiver side
   input wire logic LIN_RX_I,
   output logic LIN_TX_O,
   output logic SYNC_RX_O,
   // Serial test interface
   input wire logic STI_DATA_I,
   output logic STI_PIN_O
);

   //------------------------------------------------------------
   // State and synchronised inputs
   //------------------------------------------------------------
   pm_pkg::mux_state_t q;
   pm_pkg::mux_state_t d;
   logic [pm_pkg::SY_W-1:0] syn;
   logic rd_hit;
   logic [31:0] rd_word;
   logic rdbk;
   logic acc_done;

   // Pads and bus input pass two flops
   pm_sync #(
      .W(pm_pkg::SY_W),
      .INIT('1)
   ) u_sync (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .async_i({LIN_RX_I, P2_PAD_I, P1_PAD_I}),
      .sync_o(syn)
   );

   //------------------------------------------------------------
   // Register read decode
   //------------------------------------------------------------
   // readback pad mirror
   assign rdbk = ~q.p2sel[pm_pkg::P2_RX_SEL] & syn[pm_pkg::SY_LIN];

   // Completing access phase
   assign acc_done = APB_I.psel & APB_I.penable & q.rsp.pready;

   always_comb begin
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      case (APB_I.paddr)
         pm_pkg::P1_SEL_ADDR: begin
            rd_word = q.p1sel;
         end
         pm_pkg::P2_SEL_ADDR: begin
            rd_word = q.p2sel;
         end
         pm_pkg::P1_DAT_ADDR: begin
            rd_word = q.p1dat;
            rd_word[1:0] = syn[pm_pkg::SY_P1 +: 2];
         end
         pm_pkg::P2_DAT_ADDR: begin
            rd_word = q.p2dat;
            rd_word[1:0] = syn[pm_pkg::SY_P2 +: 2];
            rd_word[pm_pkg::P2_RDBK_PAD] = rdbk;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      d = q;
      d.rsp.pready = 1'b0;
      // Bus slave, one wait-free access
      case (q.st)
         pm_pkg::ST_IDLE: begin
            if (APB_I.psel && !APB_I.penable) begin
               d.rsp.pready = 1'b1;
               d.rsp.pslverr = ~rd_hit;
               d.rsp.prdata = APB_I.pwrite ? 32'h0000_0000 : rd_word;
               d.st = pm_pkg::ST_ACCESS;
            end
         end
         pm_pkg::ST_ACCESS: begin
            if (acc_done && APB_I.pwrite) begin
               case (APB_I.paddr)
                  pm_pkg::P1_SEL_ADDR: begin
                     d.p1sel = (APB_I.pwdata & pm_pkg::P1_SEL_WMASK) |
                               (pm_pkg::P1_SEL_RST & ~pm_pkg::P1_SEL_WMASK);
                  end
                  pm_pkg::P2_SEL_ADDR: begin
                     d.p2sel = (APB_I.pwdata & pm_pkg::P2_SEL_WMASK) |
                               (pm_pkg::P2_SEL_RST & ~pm_pkg::P2_SEL_WMASK);
                  end
                  pm_pkg::P1_DAT_ADDR: begin
                     d.p1dat = APB_I.pwdata & pm_pkg::P1_DAT_WMASK;
                  end
                  pm_pkg::P2_DAT_ADDR: begin
                     d.p2dat = APB_I.pwdata & pm_pkg::P2_DAT_WMASK;
                  end
                  default: begin
                     d.p1dat = q.p1dat;
                  end
               endcase
            end
            d.rsp.prdata = 32'h0000_0000;
            d.rsp.pslverr = 1'b0;
            d.st = pm_pkg::ST_IDLE;
         end
         default: begin
            d.st = pm_pkg::ST_IDLE;
         end
      endcase

      d.p1_o = d.p1dat[pm_pkg::OUT_LSB +: 2];
      d.p1_oe = d.p1dat[pm_pkg::DIR_LSB +: 2];
      d.p2_o = d.p2dat[pm_pkg::OUT_LSB +: 2];
      d.p2_oe = d.p2dat[pm_pkg::DIR_LSB +: 2];

      if (d.p1sel[pm_pkg::P1_TX_SEL]) begin
         d.p1_o[1] = UART_TX_I;
         d.p1_oe[1] = 1'b1;
      end
      if (d.p1sel[pm_pkg::P1_RX_SEL]) begin
         d.p1_o[0] = 1'b0;
         d.p1_oe[0] = 1'b0;
      end
      // bus data forwarded to pin 1
      if (d.p2sel[pm_pkg::P2_FWD_SEL]) begin
         d.p2_o[1] = syn[pm_pkg::SY_LIN];
         d.p2_oe[1] = 1'b1;
      end
      if (d.p2sel[pm_pkg::P2_THRU_SEL]) begin
         d.p2_o[0] = 1'b0;
         d.p2_oe[0] = 1'b0;
      end

      // Bus transmit source
      if (d.p2sel[pm_pkg::P2_TX_SEL]) begin
         d.lin_tx = UART_TX_I;
      end else if (d.p2sel[pm_pkg::P2_THRU_SEL]) begin
         d.lin_tx = syn[pm_pkg::SY_P2];
      end else begin
         d.lin_tx = d.p2dat[pm_pkg::OUT_LSB + pm_pkg::P2_WR_PAD];
      end

      // bus input to sync and UART
      d.sync_rx = d.p2sel[pm_pkg::P2_RX_SEL] ? syn[pm_pkg::SY_LIN] : 1'b1;
      if (d.p1sel[pm_pkg::P1_RX_SEL]) begin
         d.uart_rx = syn[pm_pkg::SY_P1];
      end else begin
         d.uart_rx = d.p2sel[pm_pkg::P2_RX_SEL] ? syn[pm_pkg::SY_LIN] : 1'b1;
      end

      if (d.p2sel[pm_pkg::P2_STI_SEL]) begin
         d.serial_test_interface = STI_DATA_I;
      end else begin
         d.serial_test_interface = d.p2dat[pm_pkg::OUT_LSB + pm_pkg::P2_STI_PAD];
      end
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         q <= pm_pkg::MUX_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flops
   assign APB_O = q.rsp;
   assign P1_PAD_O = q.p1_o;
   assign P1_PAD_OE_O = q.p1_oe;
   assign P2_PAD_O = q.p2_o;
   assign P2_PAD_OE_O = q.p2_oe;
   assign LIN_TX_O = q.lin_tx;
   assign UART_RX_O = q.uart_rx;
   assign SYNC_RX_O = q.sync_rx;
   assign STI_PIN_O = q.serial_test_interface;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RESETN_I);

   // Write request completing this edge
   logic wr_p1sel;
   logic wr_p2sel;
   assign wr_p1sel = acc_done & APB_I.pwrite & (APB_I.paddr == pm_pkg::P1_SEL_ADDR);
   assign wr_p2sel = acc_done & APB_I.pwrite & (APB_I.paddr == pm_pkg::P2_SEL_ADDR);

   // transmit on port 1 pin 1
   chk_p1_tx_route: assert property (
      $past(RESETN_I) && q.p1sel[pm_pkg::P1_TX_SEL]
      |-> P1_PAD_OE_O[1] && P1_PAD_O[1] == $past(UART_TX_I))
      else $error("port 1 pin 1 not carrying UART transmit");

   chk_p1_rx_route: assert property (
      $past(RESETN_I) && q.p1sel[pm_pkg::P1_RX_SEL]
      |-> !P1_PAD_OE_O[0] && UART_RX_O == $past(syn[pm_pkg::SY_P1]))
      else $error("port 1 pin 0 not feeding UART receive");

   chk_sti_gate: assert property (
      $past(RESETN_I) |-> STI_PIN_O == (q.p2sel[pm_pkg::P2_STI_SEL] ? $past(STI_DATA_I)
                                        : q.p2dat[pm_pkg::OUT_LSB + pm_pkg::P2_STI_PAD]))
      else $error("test data pin routing wrong");

   chk_lin_tx_uart: assert property (
      $past(RESETN_I) && q.p2sel[pm_pkg::P2_TX_SEL] |-> LIN_TX_O == $past(UART_TX_I))
      else $error("bus transmit not from UART");

   chk_lin_tx_pad: assert property (
      !q.p2sel[pm_pkg::P2_TX_SEL] && !q.p2sel[pm_pkg::P2_THRU_SEL]
      |-> LIN_TX_O == q.p2dat[pm_pkg::OUT_LSB + pm_pkg::P2_WR_PAD])
      else $error("bus transmit not from write pad");

   chk_rx_path_on: assert property (
      $past(RESETN_I) && q.p2sel[pm_pkg::P2_RX_SEL] && !q.p1sel[pm_pkg::P1_RX_SEL]
      |-> SYNC_RX_O == $past(syn[pm_pkg::SY_LIN]) && UART_RX_O == SYNC_RX_O)
      else $error("bus input not reaching sync and UART");

   chk_rx_path_off: assert property (
      !q.p2sel[pm_pkg::P2_RX_SEL] |-> SYNC_RX_O && (q.p1sel[pm_pkg::P1_RX_SEL] || UART_RX_O))
      else $error("bus input path not idle");

   // forward to port 2 pin 1
   chk_p2_fwd: assert property (
      $past(RESETN_I) && q.p2sel[pm_pkg::P2_FWD_SEL]
      |-> P2_PAD_OE_O[1] && P2_PAD_O[1] == $past(syn[pm_pkg::SY_LIN]))
      else $error("bus data not forwarded to port 2 pin 1");

   chk_p2_thru: assert property (
      $past(RESETN_I) && q.p2sel[pm_pkg::P2_THRU_SEL] && !q.p2sel[pm_pkg::P2_TX_SEL]
      |-> !P2_PAD_OE_O[0] && LIN_TX_O == $past(syn[pm_pkg::SY_P2]))
      else $error("port 2 pin 0 not passed to bus pin");

   chk_sel_write: assert property (
      wr_p1sel |=> q.p1sel == (($past(APB_I.pwdata) & pm_pkg::P1_SEL_WMASK)
      | (pm_pkg::P1_SEL_RST & ~pm_pkg::P1_SEL_WMASK)))
      else $error("port 1 select write not stored");

   chk_gpio_pad: assert property (
      !q.p1sel[pm_pkg::P1_TX_SEL] |-> P1_PAD_OE_O[1] == q.p1dat[pm_pkg::DIR_LSB + 1]
      && P1_PAD_O[1] == q.p1dat[pm_pkg::OUT_LSB + 1])
      else $error("GPIO pad not following data register");

   // port 1 pin 0 as GPIO
   chk_p1_gpio_pin0: assert property (
      !q.p1sel[pm_pkg::P1_RX_SEL] |-> P1_PAD_OE_O[0] == q.p1dat[pm_pkg::DIR_LSB]
      && P1_PAD_O[0] == q.p1dat[pm_pkg::OUT_LSB])
      else $error("port 1 pin 0 not following data register");

   // port 2 pin 0 as GPIO
   chk_p2_gpio_pin0: assert property (
      !q.p2sel[pm_pkg::P2_THRU_SEL] |-> P2_PAD_OE_O[0] == q.p2dat[pm_pkg::DIR_LSB]
      && P2_PAD_O[0] == q.p2dat[pm_pkg::OUT_LSB])
      else $error("port 2 pin 0 not following data register");

   chk_sel_reserved: assert property (
      (q.p1sel & ~pm_pkg::P1_SEL_WMASK) == (pm_pkg::P1_SEL_RST & ~pm_pkg::P1_SEL_WMASK)
      && (q.p2sel & ~pm_pkg::P2_SEL_WMASK) == (pm_pkg::P2_SEL_RST & ~pm_pkg::P2_SEL_WMASK))
      else $error("reserved select bits changed");

   // unchanged select bit keeps its route
   chk_route_hold: assert property (
      wr_p2sel && APB_I.pwdata[pm_pkg::P2_STI_SEL] == q.p2sel[pm_pkg::P2_STI_SEL]
      |=> $stable(q.p2sel[pm_pkg::P2_STI_SEL]))
      else $error("unchanged select bit disturbed by write");

   // Response fields idle between answers
   chk_rsp_quiet: assert property (
      !APB_O.pready |-> APB_O.prdata == 32'h0000_0000 && !APB_O.pslverr)
      else $error("bus response not idle");

   // routing changes on the same edge that stores the write
   chk_route_timing: assert property (
      wr_p2sel && APB_I.pwdata[pm_pkg::P2_FWD_SEL] |=> P2_PAD_OE_O[1])
      else $error("pad routing late after select write");

   // Answer in the first access cycle
   chk_apb_answer: assert property (
      q.st == pm_pkg::ST_IDLE && APB_I.psel && !APB_I.penable |=> APB_O.pready ##1 !APB_O.pready)
      else $error("bus answer timing wrong");

   // Main scenarios
   cov_lin_mode: cover property (
      q.p2sel[pm_pkg::P2_TX_SEL] && q.p2sel[pm_pkg::P2_RX_SEL]);
   cov_standalone: cover property (
      q.p2sel[pm_pkg::P2_THRU_SEL] && q.p2sel[pm_pkg::P2_FWD_SEL]);
   cov_uart_pins: cover property (
      wr_p1sel ##1 q.p1sel[pm_pkg::P1_TX_SEL] && q.p1sel[pm_pkg::P1_RX_SEL]);
   cov_bad_addr: cover property (APB_O.pready && APB_O.pslverr);
   cov_sti_route: cover property (q.p2sel[pm_pkg::P2_STI_SEL] && STI_PIN_O);

endmodule // pm_mux

// *** core/pm_pkg.sv ***
//------------------------------------------------------------
// Purpose: Constants and types of the port 1/2 function mux
// Assumes: APB slave, 32-bit words, one clock
// Notes: Overview of operation follows
//------------------------------------------------------------
// Overview of operation
// - Port 1 select bit 4 set drives UART transmit data on port 1 pin 1, else that pin is GPIO.
// - Port 1 select bit 0 set feeds port 1 pin 0 to UART receive, else that pin is GPIO.
// - Port 2 select bit 24 set routes test interface data to its pin, cleared keeps it off the pin.
// - Port 2 select bit 20 set sends UART transmit data to the bus data pin for LIN use.
// - Port 2 select bits 20 and 0 clear take bus transmit data from the write pad set by the port 2 data register.
// - Port 2 select bit 16 set feeds bus input to sync logic, and to UART receive unless port 1 select bit 0 is set; software sets it for bus modes.
// - Port 2 select bit 16 clear disables the bus input path and the readback pad mirrors the bus pin.
// - Port 2 select bit 4 set forwards received bus data to port 2 pin 1, else that pin is GPIO.
// - Port 2 select bit 0 set makes port 2 pin 0 an input passed through to the bus pin unless bit 20 is set, else that pin is GPIO.
// - Each select register is a 32-bit read/write memory mapped word choosing its port's pin functions.
// - A GPIO pad takes direction and output from its data register, and reads return the pad state.
package pm_pkg;

   //------------------------------------------------------------
   // Register map
   //------------------------------------------------------------
   localparam logic [31:0] P1_SEL_ADDR = 32'hFFFF_0D04;
   localparam logic [31:0] P2_SEL_ADDR = 32'hFFFF_0D08;
   localparam logic [31:0] P1_DAT_ADDR = 32'hFFFF_0D30;
   localparam logic [31:0] P2_DAT_ADDR = 32'hFFFF_0D40;

   // Values after reset
   localparam logic [31:0] P1_SEL_RST = 32'h1000_0000;
   localparam logic [31:0] P2_SEL_RST = 32'h0100_0000;
   localparam logic [31:0] DAT_RST = 32'h0000_0000;

   // Writable bits, the rest hold their reset value
   localparam logic [31:0] P1_SEL_WMASK = 32'h0000_0011;
   localparam logic [31:0] P2_SEL_WMASK = 32'h0111_0011;
   localparam logic [31:0] P1_DAT_WMASK = 32'h0303_0000;
   localparam logic [31:0] P2_DAT_WMASK = 32'h6363_0000;

   //------------------------------------------------------------
   // Field positions
   //------------------------------------------------------------
   localparam int P1_RX_SEL = 0;
   localparam int P1_TX_SEL = 4;
   localparam int P2_THRU_SEL = 0;
   localparam int P2_FWD_SEL = 4;
   localparam int P2_RX_SEL = 16;
   localparam int P2_TX_SEL = 20;
   localparam int P2_STI_SEL = 24;
   localparam int DIR_LSB = 24;
   localparam int OUT_LSB = 16;
   localparam int P2_RDBK_PAD = 4;
   localparam int P2_WR_PAD = 5;
   localparam int P2_STI_PAD = 6;

   // Synchroniser lanes
   localparam int SY_W = 5;
   localparam int SY_P1 = 0;
   localparam int SY_P2 = 2;
   localparam int SY_LIN = 4;

   //------------------------------------------------------------
   // Types
   //------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACCESS = 2'b10
   } apb_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed {
      apb_state_t st;
      logic [31:0] p1sel;
      logic [31:0] p2sel;
      logic [31:0] p1dat;
      logic [31:0] p2dat;
      apb_rsp_t rsp;
      logic [1:0] p1_o;
      logic [1:0] p1_oe;
      logic [1:0] p2_o;
      logic [1:0] p2_oe;
      logic lin_tx;
      logic uart_rx;
      logic sync_rx;
      logic serial_test_interface;
   } mux_state_t;

   localparam mux_state_t MUX_RST = '{
      st: ST_IDLE, p1sel: P1_SEL_RST, p2sel: P2_SEL_RST,
      p1dat: DAT_RST, p2dat: DAT_RST,
      rsp: '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0},
      p1_o: 2'h0, p1_oe: 2'h0, p2_o: 2'h0, p2_oe: 2'h0,
      lin_tx: 1'b0, uart_rx: 1'b1, sync_rx: 1'b1, serial_test_interface: 1'b0};

endpackage

// *** core/pm_sync.sv ***
//------------------------------------------------------------
// Purpose: Two-flop synchroniser for pad inputs
// Assumes: Inputs asynchronous to REF_CLK_I
// Notes: First stage feeds only the second
//------------------------------------------------------------
`timescale 1ns/1ns
module pm_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Data
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   // Shift one stage per clock
   always_comb begin
      d.s1 = async_i;
      d.s2 = q.s1;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '{s1: INIT, s2: INIT};
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.s2;

endmodule // pm_sync

// *** test/lin_uart_partner.sv ***
//------------------------------------------------------------
// Purpose: UART and bus transceiver stand-in facing the mux
// Assumes: Levels chosen by the bench, one clock
// Notes: Echo mode reads the bus back the way a transceiver does
//------------------------------------------------------------
`timescale 1ns/1ns
module lin_uart_partner (
   // Clock
   input wire logic clk_i,
   // Levels from the bench
   input wire logic utx_i,
   input wire logic sti_i,
   input wire logic lrx_i,
   input wire logic echo_i,
   // Mux side
   input wire logic lin_tx_i,
   output logic uart_tx_o,
   output logic sti_o,
   output logic lin_rx_o
);
   // Known levels before the first edge
   initial begin
      uart_tx_o = 1'b1;
      sti_o = 1'b0;
      lin_rx_o = 1'b1;
   end

   // Launch levels just after each edge; echo adds one cycle of bus delay
   always @(posedge clk_i) begin
      uart_tx_o <= utx_i;
      sti_o <= sti_i;
      lin_rx_o <= echo_i ? lin_tx_i : lrx_i;
   end
endmodule // lin_uart_partner

// *** test/port1_port2_function_mux_bench.sv ***
//------------------------------------------------------------
// Purpose: Self-checking bench of the port 1/2 function mux
// Assumes: Zero-wait APB slave, pads resolved in the bench
// Notes: Table of routing cases, then reset and corner cases
//------------------------------------------------------------
`timescale 1ns/1ns
module port1_port2_function_mux_bench;
   // Row: p1 {sel4,sel0}, p2 {sel24,sel20,sel16,sel4,sel0},
   // levels {utx,sti,lrx,echo,p1pad0,p2pad0}, expected outputs
   typedef struct packed {logic [1:0] p1; logic [4:0] p2; logic [5:0] lv; logic [7:0] ex;} row_t;
   localparam int NROW = 10;
   localparam row_t ROWS [NROW] = '{
      '{2'h0, 5'h00, 6'h30, 8'hA0}, '{2'h2, 5'h10, 6'h30, 8'hBC},
      '{2'h1, 5'h00, 6'h08, 8'h20}, '{2'h0, 5'h04, 6'h00, 8'h00},
      '{2'h0, 5'h08, 6'h20, 8'hE0}, '{2'h0, 5'h01, 6'h01, 8'hE0},
      '{2'h0, 5'h09, 6'h01, 8'hA0}, '{2'h0, 5'h02, 6'h08, 8'hA3},
      '{2'h0, 5'h0C, 6'h04, 8'h00}, '{2'h3, 5'h1F, 6'h22, 8'hCD}};

   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   pm_pkg::apb_req_t apb_req = '0;
   pm_pkg::apb_rsp_t apb_rsp;
   logic [1:0] p1_ext = 2'h0;
   logic [1:0] p2_ext = 2'h0;
   logic [1:0] p1_o, p1_oe, p2_o, p2_oe;
   wire [1:0] p1_pad, p2_pad;
   logic utx = 1'b1;
   logic serial_test_interface = 1'b0;
   logic lrx = 1'b1;
   logic echo = 1'b0;
   wire uart_tx, sti_d, lin_rx, uart_rx, lin_tx, sync_rx, sti_pin;
   int miscompares = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic err;

   // Clock and resolved pad levels
   always #50 ref_clk = ~ref_clk;
   assign p1_pad = (p1_oe & p1_o) | (~p1_oe & p1_ext);
   assign p2_pad = (p2_oe & p2_o) | (~p2_oe & p2_ext);

   pm_mux dut (.REF_CLK_I(ref_clk), .RESETN_I(resetn), .APB_I(apb_req), .APB_O(apb_rsp),
      .P1_PAD_I(p1_pad), .P1_PAD_O(p1_o), .P1_PAD_OE_O(p1_oe),
      .P2_PAD_I(p2_pad), .P2_PAD_O(p2_o), .P2_PAD_OE_O(p2_oe),
      .UART_TX_I(uart_tx), .UART_RX_O(uart_rx), .LIN_RX_I(lin_rx), .LIN_TX_O(lin_tx),
      .SYNC_RX_O(sync_rx), .STI_DATA_I(sti_d), .STI_PIN_O(sti_pin));

   lin_uart_partner far (.clk_i(ref_clk), .utx_i(utx), .sti_i(serial_test_interface), .lrx_i(lrx), .echo_i(echo),
      .lin_tx_i(lin_tx), .uart_tx_o(uart_tx), .sti_o(sti_d), .lin_rx_o(lin_rx));

   //------------------------------------------------------------
   // Shared tasks
   //------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         miscompares++;
      end
   endtask

   task automatic finish_test();
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      @(posedge ref_clk);
      while (apb_rsp.pready !== 1'b1 && n < 16) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 16) begin
         miscompares++;
         finish_test();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      logic [31:0] w1, w2;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int i = 0; i < NROW; i++) begin
         w1 = {27'h0, ROWS[i].p1[1], 3'h0, ROWS[i].p1[0]};
         w2 = {7'h0, ROWS[i].p2[4], 3'h0, ROWS[i].p2[3], 3'h0, ROWS[i].p2[2], 11'h0, ROWS[i].p2[1], 3'h0,
            ROWS[i].p2[0]};
         apb(1'b1, pm_pkg::P1_SEL_ADDR, w1);
         apb(1'b1, pm_pkg::P2_SEL_ADDR, w2);
         {utx, serial_test_interface, lrx, echo, p1_ext[0], p2_ext[0]} <= ROWS[i].lv;
         repeat (8) @(posedge ref_clk);
         check({22'h0, uart_rx, lin_tx, sync_rx, sti_pin, p1_o[1], p1_oe[1], p2_o[1], p2_oe[1], p1_oe[0],
            p2_oe[0]}, {22'h0, ROWS[i].ex, 2'h0});
         apb(1'b0, pm_pkg::P1_SEL_ADDR, 32'h0);
         check(rd, w1 | (pm_pkg::P1_SEL_RST & ~pm_pkg::P1_SEL_WMASK));
         apb(1'b0, pm_pkg::P2_SEL_ADDR, 32'h0);
         check(rd, w2 | (pm_pkg::P2_SEL_RST & ~pm_pkg::P2_SEL_WMASK));
      end
      // Second reset in mid-run
      resetn <= 1'b0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      apb(1'b0, pm_pkg::P1_SEL_ADDR, 32'h0);
      check(rd, 32'h1000_0000);
      apb(1'b0, pm_pkg::P2_SEL_ADDR, 32'h0);
      check(rd, 32'h0100_0000);
      // Unmapped word answers with an error and no data
      apb(1'b0, 32'hFFFF_0D0C, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, pm_pkg::P1_DAT_ADDR, 32'h0303_0000);
      repeat (4) @(posedge ref_clk);
      check({28'h0, p1_oe, p1_o}, 32'hF);
      apb(1'b0, pm_pkg::P1_DAT_ADDR, 32'h0);
      check(rd, 32'h0303_0003);
      {utx, echo, lrx} <= 3'h1;
      apb(1'b1, pm_pkg::P2_DAT_ADDR, 32'h0121_0000);
      repeat (4) @(posedge ref_clk);
      check({31'h0, lin_tx}, 32'h1);
      check({30'h0, p2_oe[0], p2_o[0]}, 32'h3);
      apb(1'b0, pm_pkg::P2_DAT_ADDR, 32'h0);
      check(rd & 32'h0000_0010, 32'h0000_0010);
      apb(1'b1, pm_pkg::P2_SEL_ADDR, 32'h0010_0000);
      #1;
      check({31'h0, lin_tx}, 32'h0);
      finish_test();
   end
endmodule // port1_port2_function_mux_bench
